// >>> rtl/ppms_pkg.sv
// Package with register map, field positions and encodings of the pin select.
package ppms_pkg;

  // Register word addresses (Avalon word index).
  localparam logic [2:0] ADDR_PORT_CONFIG = 3'h0;
  localparam logic [2:0] ADDR_DIRECTION = 3'h1;
  localparam logic [2:0] ADDR_CHAN_SELECT = 3'h2;
  localparam logic [2:0] ADDR_CMP0_CTL = 3'h3;
  localparam logic [2:0] ADDR_CMP1_CTL = 3'h4;
  localparam logic [2:0] ADDR_CMP2_CTL = 3'h5;
  localparam logic [2:0] ADDR_PIN_STATUS = 3'h6;
  localparam logic [2:0] ADDR_PIN_LEVEL = 3'h7;

  // Shared pins: index 0..2 are comparator positive pins, 3 is common pin.
  localparam int NUM_PINS = 4;
  localparam int NUM_CMP = 3;
  localparam logic [3:0] PIN_INDEX_MASK = 4'hF;

  // Channel numbers of the shared pins (analog_channel_n, n = 3..6).
  localparam logic [3:0] CHAN_PIN0 = 4'h3;
  localparam logic [3:0] CHAN_PIN1 = 4'h4;
  localparam logic [3:0] CHAN_PIN2 = 4'h5;
  localparam logic [3:0] CHAN_COMMON = 4'h6;

  // Comparator control register field positions.
  localparam int CMP_ROUTE_EN_BIT = 7;
  localparam int CMP_MODE_HIGH_BIT = 4;
  localparam int CMP_MODE_LOW_BIT = 3;

  // Reset values: digital mode, input direction, channel 0, all disabled.
  localparam logic [3:0] PORT_CONFIG_RST = 4'h0;
  localparam logic [3:0] DIRECTION_RST = 4'hF;
  localparam logic [3:0] CHAN_SELECT_RST = 4'h0;
  localparam logic [7:0] CMP_CTL_RST = 8'h00;

  // Status field layout per pin (4 bits each).
  localparam int ST_CONVERT = 0;
  localparam int ST_CMP_IN = 1;
  localparam int ST_DIGITAL = 2;
  localparam int ST_PROHIBITED = 3;
  localparam int ST_WIDTH = 4;

  typedef enum {BUS_IDLE, BUS_ANSWER} ppms_bus_state_type;

endpackage

// >>> rtl/ppms_pin_select.sv
// Port-2 shared pin function select with Avalon-MM register access.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
module ppms_pin_select (
  // Clock and reset.
  input wire logic refClk,
  input wire logic rstn,
  // Avalon-MM slave.
  input wire logic [2:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  output logic avsResponseErr,
  // Shared pins: digital side.
  input wire logic [ppms_pkg::NUM_PINS-1:0] pinIn,
  output logic [ppms_pkg::NUM_PINS-1:0] pinOut,
  output logic [ppms_pkg::NUM_PINS-1:0] pinOe,
  // Analog routing controls.
  output logic [ppms_pkg::NUM_PINS-1:0] convertRoute,
  output logic [ppms_pkg::NUM_PINS-1:0] analogMode,
  output logic [ppms_pkg::NUM_CMP-1:0] comparatorPosRoute,
  output logic [ppms_pkg::NUM_CMP-1:0] comparatorCommonRoute,
  output logic [ppms_pkg::NUM_PINS-1:0] prohibitedSetting
);
  import ppms_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] portConfig_r, portConfig_nxt;
  logic [3:0] direction_r, direction_nxt;
  logic [3:0] portData_r, portData_nxt;
  logic [3:0] chanSelect_r, chanSelect_nxt;
  logic [7:0] cmpCtl_r [NUM_CMP];
  logic [7:0] cmpCtl_nxt [NUM_CMP];
  logic [31:0] readData_r, readData_nxt;
  logic respErr_r, respErr_nxt;
  ppms_bus_state_type busState_r, busState_nxt;
  logic [NUM_PINS-1:0] convert_r, convert_nxt;
  logic [NUM_PINS-1:0] analog_r, analog_nxt;
  logic [NUM_CMP-1:0] cmpPos_r, cmpPos_nxt;
  logic [NUM_CMP-1:0] comparator_common_input_r, comparator_common_input_nxt;
  logic [NUM_PINS-1:0] prohib_r, prohib_nxt;
  logic [NUM_PINS-1:0] pinOut_r, pinOut_nxt;
  logic [NUM_PINS-1:0] pinOe_r, pinOe_nxt;
  logic [3:0] pinChan [NUM_PINS];
  logic [NUM_PINS-1:0] chanHit;
  logic [NUM_PINS*ST_WIDTH-1:0] statusWord;
  logic cmpEn [NUM_CMP];
  logic cmpComSel [NUM_CMP];
  logic reqValid;
  logic [NUM_PINS-1:0] pinAnalogIn;
  logic [31:0] readMux;
  logic wrLane0;
  logic wrLane1;

  assign pinChan[0] = CHAN_PIN0;
  assign pinChan[1] = CHAN_PIN1;
  assign pinChan[2] = CHAN_PIN2;
  assign pinChan[3] = CHAN_COMMON;

  // ----------------------------------------------------------------
  // Per-pin routing decode
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign chanHit[gi] = (chanSelect_r == pinChan[gi]);
      // Analog mode with input direction is the base of every route.
      assign pinAnalogIn[gi] = portConfig_r[gi] & direction_r[gi];
      assign statusWord[gi*ST_WIDTH+ST_CONVERT] = convert_r[gi];
      assign statusWord[gi*ST_WIDTH+ST_DIGITAL] = ~analog_r[gi];
      assign statusWord[gi*ST_WIDTH+ST_PROHIBITED] = prohib_r[gi];
      if (gi < NUM_CMP) begin : g_pos
        assign statusWord[gi*ST_WIDTH+ST_CMP_IN] = cmpPos_r[gi];
      end else begin : g_com
        // The common pin reports any comparator that uses it.
        assign statusWord[gi*ST_WIDTH+ST_CMP_IN] = |comparator_common_input_r;
      end
    end
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      assign cmpEn[gi] = cmpCtl_r[gi][CMP_ROUTE_EN_BIT];
      assign cmpComSel[gi] = cmpCtl_r[gi][CMP_MODE_HIGH_BIT] &
          cmpCtl_r[gi][CMP_MODE_LOW_BIT];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next routing state
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      analog_nxt[i] = portConfig_r[i];
      // Analog pin in input mode: converted only when selected.
      convert_nxt[i] = pinAnalogIn[i] & chanHit[i];
      // Digital pin selected, or analog pin driven out, is prohibited.
      prohib_nxt[i] = (~portConfig_r[i] & chanHit[i]) |
          (portConfig_r[i] & ~direction_r[i]);
      // Digital pins drive only in output mode; analog pins never drive.
      pinOe_nxt[i] = ~portConfig_r[i] & ~direction_r[i];
      pinOut_nxt[i] = pinOe_nxt[i] & portData_r[i];
    end
    for (int m = 0; m < NUM_CMP; m++) begin
      // The comparator route is added beside any conversion route.
      cmpPos_nxt[m] = pinAnalogIn[m] & cmpEn[m];
      comparator_common_input_nxt[m] = pinAnalogIn[NUM_PINS-1] & cmpComSel[m];
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, answer on the second cycle
  // ----------------------------------------------------------------
  assign reqValid = avsRead | avsWrite;
  // Byte lanes that carry the writable fields.
  assign wrLane0 = avsWrite & avsByteEnable[0];
  assign wrLane1 = avsWrite & avsByteEnable[1];

  // ----------------------------------------------------------------
  // Read-back multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    readMux = '0;
    case (avsAddress)
      ADDR_PORT_CONFIG: begin
        readMux[3:0] = portConfig_r;
      end
      ADDR_DIRECTION: begin
        readMux[3:0] = direction_r;
        readMux[11:8] = portData_r;
      end
      ADDR_CHAN_SELECT: begin
        readMux[3:0] = chanSelect_r;
      end
      ADDR_CMP0_CTL: begin
        readMux[7:0] = cmpCtl_r[0];
      end
      ADDR_CMP1_CTL: begin
        readMux[7:0] = cmpCtl_r[1];
      end
      ADDR_CMP2_CTL: begin
        readMux[7:0] = cmpCtl_r[2];
      end
      ADDR_PIN_STATUS: begin
        readMux[NUM_PINS*ST_WIDTH-1:0] = statusWord;
      end
      ADDR_PIN_LEVEL: begin
        // Analog pins read as low so that no stale level leaks out.
        readMux[NUM_PINS-1:0] = pinIn & ~analog_r;
      end
      default: begin
        readMux = '0;
      end
    endcase
  end

  always_comb begin
    portConfig_nxt = portConfig_r;
    direction_nxt = direction_r;
    portData_nxt = portData_r;
    chanSelect_nxt = chanSelect_r;
    for (int m = 0; m < NUM_CMP; m++) begin
      cmpCtl_nxt[m] = cmpCtl_r[m];
    end
    readData_nxt = readData_r;
    respErr_nxt = respErr_r;
    busState_nxt = busState_r;
    // A request is taken in idle; the answer cycle drops waitrequest.
    case (busState_r)
      BUS_IDLE: begin
        if (reqValid) begin
          busState_nxt = BUS_ANSWER;
          respErr_nxt = 1'b0;
          readData_nxt = readMux;
          case (avsAddress)
            ADDR_PORT_CONFIG: begin
              if (wrLane0) begin
                portConfig_nxt = avsWriteData[3:0];
              end
            end
            ADDR_DIRECTION: begin
              if (wrLane0) begin
                direction_nxt = avsWriteData[3:0];
              end
              if (wrLane1) begin
                portData_nxt = avsWriteData[11:8];
              end
            end
            ADDR_CHAN_SELECT: begin
              if (wrLane0) begin
                chanSelect_nxt = avsWriteData[3:0];
              end
            end
            ADDR_CMP0_CTL: begin
              if (wrLane0) begin
                cmpCtl_nxt[0] = avsWriteData[7:0];
              end
            end
            ADDR_CMP1_CTL: begin
              if (wrLane0) begin
                cmpCtl_nxt[1] = avsWriteData[7:0];
              end
            end
            ADDR_CMP2_CTL: begin
              if (wrLane0) begin
                cmpCtl_nxt[2] = avsWriteData[7:0];
              end
            end
            ADDR_PIN_STATUS, ADDR_PIN_LEVEL: begin
              // Read-only words ignore writes.
            end
            default: begin
              respErr_nxt = 1'b1;
            end
          endcase
        end
      end
      BUS_ANSWER: begin
        busState_nxt = BUS_IDLE;
      end
      default: begin
        busState_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge refClk or negedge rstn) begin
    if (!rstn) begin
      portConfig_r <= PORT_CONFIG_RST;
      direction_r <= DIRECTION_RST;
      portData_r <= '0;
      chanSelect_r <= CHAN_SELECT_RST;
      for (int m = 0; m < NUM_CMP; m++) begin
        cmpCtl_r[m] <= CMP_CTL_RST;
      end
      readData_r <= '0;
      respErr_r <= 1'b0;
      busState_r <= BUS_IDLE;
    end else begin
      portConfig_r <= portConfig_nxt;
      direction_r <= direction_nxt;
      portData_r <= portData_nxt;
      chanSelect_r <= chanSelect_nxt;
      for (int m = 0; m < NUM_CMP; m++) begin
        cmpCtl_r[m] <= cmpCtl_nxt[m];
      end
      readData_r <= readData_nxt;
      respErr_r <= respErr_nxt;
      busState_r <= busState_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Routing registers
  // ----------------------------------------------------------------
  // Routing follows a register write by one clock, so that all
  // routes of one setting change together and never glitch.
  always_ff @(posedge refClk or negedge rstn) begin
    if (!rstn) begin
      convert_r <= '0;
      analog_r <= '0;
      cmpPos_r <= '0;
      comparator_common_input_r <= '0;
      prohib_r <= '0;
      pinOut_r <= '0;
      pinOe_r <= '0;
    end else begin
      convert_r <= convert_nxt;
      analog_r <= analog_nxt;
      cmpPos_r <= cmpPos_nxt;
      comparator_common_input_r <= comparator_common_input_nxt;
      prohib_r <= prohib_nxt;
      pinOut_r <= pinOut_nxt;
      pinOe_r <= pinOe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avsWaitRequest = reqValid & (busState_r != BUS_ANSWER);
  assign avsReadData = readData_r;
  assign avsResponseErr = respErr_r;
  assign pinOut = pinOut_r;
  assign pinOe = pinOe_r;
  assign convertRoute = convert_r;
  assign analogMode = analog_r;
  assign comparatorPosRoute = cmpPos_r;
  assign comparatorCommonRoute = comparator_common_input_r;
  assign prohibitedSetting = prohib_r;

endmodule // ppms_pin_select

// >>> tb/ppms_props.sv
// Checker of the pin select port behaviour.
`timescale 1ns/1ns
module ppms_props (
  // Clock, reset and bus.
  input wire logic refClk,
  input wire logic rstn,
  input wire logic [2:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic avsResponseErr,
  // Pins and routing.
  input wire logic [ppms_pkg::NUM_PINS-1:0] pinIn,
  input wire logic [ppms_pkg::NUM_PINS-1:0] pinOut,
  input wire logic [ppms_pkg::NUM_PINS-1:0] pinOe,
  input wire logic [ppms_pkg::NUM_PINS-1:0] convertRoute,
  input wire logic [ppms_pkg::NUM_PINS-1:0] analogMode,
  input wire logic [ppms_pkg::NUM_CMP-1:0] comparatorPosRoute,
  input wire logic [ppms_pkg::NUM_CMP-1:0] comparatorCommonRoute,
  input wire logic [ppms_pkg::NUM_PINS-1:0] prohibitedSetting
);
  import ppms_pkg::*;
  wire logic wrDone = avsWrite && !avsWaitRequest && avsByteEnable[0];
  wire logic cmp0Wr = wrDone && avsAddress == ADDR_CMP0_CTL;
  default clocking cb @(posedge refClk); endclocking
  default disable iff (!rstn);
  one_wait_a: assert property ((avsRead || avsWrite) && avsWaitRequest
    |=> !avsWaitRequest) else $error("answer not after one wait");
  no_drive_a: assert property ((pinOe & analogMode) == 4'h0)
    else $error("analog pin driven");
  out_gate_a: assert property ((pinOut & ~pinOe) == 4'h0)
    else $error("output data without enable");
  conv_mode_a: assert property ((convertRoute & ~analogMode) == 4'h0)
    else $error("digital pin converted");
  conv_one_a: assert property ($onehot0(convertRoute))
    else $error("more than one pin converted");
  conv_bad_a: assert property (
    (convertRoute & prohibitedSetting) == 4'h0)
    else $error("prohibited pin converted");
  pos_mode_a: assert property (
    (comparatorPosRoute & ~analogMode[2:0]) == 3'h0)
    else $error("digital pin to comparator");
  com_mode_a: assert property (
    |comparatorCommonRoute |-> analogMode[3])
    else $error("digital common pin routed");
  chan_off_a: assert property (
    wrDone && avsAddress == ADDR_CHAN_SELECT &&
    avsWriteData[3:0] == 4'h0 |=> ##1 convertRoute == 4'h0)
    else $error("unselected pin converted");
  route_en_a: assert property (
    cmp0Wr && !avsWriteData[CMP_ROUTE_EN_BIT]
    |=> ##1 !comparatorPosRoute[0]) else $error("route without enable");
  mode_bits_a: assert property (
    cmp0Wr && !(avsWriteData[CMP_MODE_HIGH_BIT] &&
    avsWriteData[CMP_MODE_LOW_BIT]) |=> ##1 !comparatorCommonRoute[0])
    else $error("common route without both mode bits");
  cover property (|comparatorPosRoute);
  cover property (|comparatorCommonRoute);
  cover property (|prohibitedSetting);
endmodule // ppms_props
bind ppms_pin_select ppms_props u_props (.refClk, .rstn, .avsAddress,
  .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .avsReadData,
  .avsWaitRequest, .avsResponseErr, .pinIn, .pinOut, .pinOe, .convertRoute,
  .analogMode, .comparatorPosRoute, .comparatorCommonRoute,
  .prohibitedSetting);

// >>> tb/tb_port2_analog_comparator_pin_select.sv
// Self-checking bench of the port-2 pin select.
`timescale 1ns/1ns
module tb_port2_analog_comparator_pin_select;
  import ppms_pkg::*;
  logic refClk = 1'b0, rstn = 1'b0, avsRead = 1'b0, avsWrite = 1'b0;
  logic [2:0] avsAddress = 3'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
  logic [3:0] avsByteEnable = 4'hF, pinIn = 4'h5;
  logic avsWaitRequest, avsResponseErr;
  logic [3:0] pinOut, pinOe, convertRoute, analogMode, prohibitedSetting;
  logic [2:0] comparatorPosRoute, comparatorCommonRoute;
  int error_cnt = 0, comparisons = 0;
  ppms_pin_select dut (.refClk, .rstn, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest,
    .avsResponseErr, .pinIn, .pinOut, .pinOe, .convertRoute, .analogMode,
    .comparatorPosRoute, .comparatorCommonRoute, .prohibitedSetting);
  initial forever #10 refClk = ~refClk;
  task report_and_stop;
    $display("errors %0d of %0d checks", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Each transfer ends half a cycle after release, with routing settled.
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge refClk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    @(negedge refClk);
    while (avsWaitRequest !== 1'b0 && n < 20) begin
      n++;
      @(negedge refClk);
    end
    if (n == 20) begin
      error_cnt++;
      report_and_stop();
    end
    rd = avsReadData;
    @(posedge refClk);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(negedge refClk);
  endtask
  task s_reset;
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, 3'(a), 32'h0);
      chk("reset reg", (a == 1) ? 32'h0000000F : 32'h0, rd);
      chk("resp err", 32'h0, 32'(avsResponseErr));
    end
    chk("idle oe", 32'(pinOe), 32'h0);
  endtask
  task s_convert;
    bus(1'b1, ADDR_PORT_CONFIG, 32'h0000000F);
    chk("analog", 32'hF, 32'(analogMode));
    for (int c = CHAN_PIN0; c <= CHAN_COMMON; c++) begin
      bus(1'b1, ADDR_CHAN_SELECT, 32'(c));
      chk("convert", 32'h1 << (c - CHAN_PIN0), 32'(convertRoute));
    end
    bus(1'b1, ADDR_CHAN_SELECT, 32'h0);
    chk("unselected", 32'h0, 32'(convertRoute));
  endtask
  task s_cmp;
    bus(1'b1, ADDR_CHAN_SELECT, 32'(CHAN_PIN1));
    for (int m = 0; m < 3; m++) begin
      bus(1'b1, 3'(ADDR_CMP0_CTL + m), 32'h80);
      chk("pos", 32'h1 << m, 32'(comparatorPosRoute));
      chk("conv", 32'h2, 32'(convertRoute));
      chk("com off", 32'h0, 32'(comparatorCommonRoute));
      bus(1'b1, 3'(ADDR_CMP0_CTL + m), 32'h18);
      chk("pos off", 32'h0, 32'(comparatorPosRoute));
      chk("com", 32'h1 << m, 32'(comparatorCommonRoute));
      bus(1'b1, 3'(ADDR_CMP0_CTL + m), 32'h10);
      chk("com hi", 32'h0, 32'(comparatorCommonRoute));
      bus(1'b1, 3'(ADDR_CMP0_CTL + m), 32'h08);
      chk("com lo", 32'h0, 32'(comparatorCommonRoute));
    end
    bus(1'b1, ADDR_PORT_CONFIG, 32'h00000007);
    bus(1'b1, ADDR_CMP0_CTL, 32'h18);
    chk("com dig", 32'h0, 32'(comparatorCommonRoute));
  endtask
  task s_digital;
    bus(1'b1, ADDR_PORT_CONFIG, 32'h0);
    bus(1'b1, ADDR_CHAN_SELECT, 32'h0);
    bus(1'b1, ADDR_DIRECTION, 32'h00000A00);
    chk("oe", 32'hF, 32'(pinOe));
    chk("out", 32'hA, 32'(pinOut));
    bus(1'b1, ADDR_DIRECTION, 32'h0000000F);
    bus(1'b0, ADDR_PIN_LEVEL, 32'h0);
    chk("level", 32'h5, 32'(rd[3:0]));
    bus(1'b1, ADDR_CHAN_SELECT, 32'(CHAN_COMMON));
    chk("bad dig", 32'h8, 32'(prohibitedSetting));
    chk("no conv", 32'h0, 32'(convertRoute));
    bus(1'b1, ADDR_PORT_CONFIG, 32'h0000000F);
    bus(1'b1, ADDR_DIRECTION, 32'h0);
    chk("bad ana", 32'hF, 32'(prohibitedSetting));
    chk("ana oe", 32'h0, 32'(pinOe));
    bus(1'b0, ADDR_PIN_STATUS, 32'h0);
    chk("status", 32'h00008888, rd);
  endtask
  initial begin
    repeat (6) @(posedge refClk);
    rstn <= 1'b1;
    s_reset();
    s_convert();
    s_cmp();
    s_digital();
    report_and_stop();
  end
endmodule // tb_port2_analog_comparator_pin_select
